// ==== logic/lpcd_regs.vh ====
`ifndef LPCD_REGS_VH
`define LPCD_REGS_VH
// ==========================================
// Command kinds; all but COL, NTCOL and RSVD can be reported on CMD_KIND
`define LPCD_K_NONE   5'h00
`define LPCD_K_MPC    5'h01
`define LPCD_K_CLOSE  5'h02
`define LPCD_K_RENEW  5'h03
`define LPCD_K_SRE    5'h04
`define LPCD_K_SRX    5'h05
`define LPCD_K_STORE  5'h06
`define LPCD_K_MSTORE 5'h07
`define LPCD_K_READ   5'h08
`define LPCD_K_COL    5'h09
`define LPCD_K_NTCOL  5'h0a
`define LPCD_K_SSET1  5'h0b
`define LPCD_K_SSET2  5'h0c
`define LPCD_K_FETCH  5'h0d
`define LPCD_K_ROW1   5'h0e
`define LPCD_K_ROW2   5'h0f
`define LPCD_K_RSVD   5'h10
// ==========================================
// First-edge patterns on command_address_pins[4:0]
`define LPCD_P_MPC    5'h00
`define LPCD_P_CLOSE  5'h10
`define LPCD_P_RENEW  5'h08
`define LPCD_P_SRE    5'h18
`define LPCD_P_SRX    5'h14
`define LPCD_P_STORE  5'h04
`define LPCD_P_MSTORE 5'h0c
`define LPCD_P_READ   5'h02
`define LPCD_P_COL    5'h12
`define LPCD_P_SSET1  5'h06
`define LPCD_P_SSET2  5'h16
`define LPCD_P_FETCH  5'h0e
// ==========================================
// Setting indices and field positions
`define LPCD_IDX_MR1   6'h01
`define LPCD_IDX_MR2   6'h02
`define LPCD_IDX_MR3   6'h03
`define LPCD_IDX_MR11  6'h0b
`define LPCD_IDX_MR13  6'h0d
`define LPCD_F_NWR     6:4
`define LPCD_F_WLS     6
`define LPCD_F_WL      5:3
`define LPCD_F_RL      2:0
`define LPCD_F_DBI     7:6
`define LPCD_F_CAODT   6:4
`define LPCD_F_DQODT   2:0
`define LPCD_F_FSP     7:6
// ==========================================
// Reset defaults (code zero: store 4, fetch 6, fetch-to-close 8, recovery 6)
`define LPCD_D_FSP   2'h0
`define LPCD_D_WLS   1'h0
`define LPCD_D_CODE  3'h0
`define LPCD_D_DBI   2'h0
`define LPCD_D_ODT   3'h0
// ==========================================
// Sequencer
`define LPCD_S_FIRST  3'h0
`define LPCD_S_SECOND 3'h1
`define LPCD_S_COLW   3'h2
`define LPCD_S_SSETW  3'h3
`define LPCD_S_ROWW   3'h4
`define LPCD_S_QUIET  3'h5
`define LPCD_QUIET_N  2'h2
`define LPCD_MPC_COLBIT 6
`endif

// ==== logic/lpcd_sync.v ====
`timescale 1ns/1ps
`default_nettype none
module lpcd_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rstn,
	// Data
	input  wire [WIDTH-1:0] d,
	output reg  [WIDTH-1:0] q
);
	reg [WIDTH-1:0] meta;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta <= {WIDTH{1'b0}};
			q    <= {WIDTH{1'b0}};
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// ==== logic/lpcd_banks.v ====
`timescale 1ns/1ps
`default_nettype none
module lpcd_banks #(
	parameter BANKS = 8
) (
	// Clock and reset
	input  wire             clk,
	input  wire             rstn,
	input  wire             clr,
	// Events
	input  wire             open_en,
	input  wire             close_en,
	input  wire             close_all,
	input  wire [2:0]       bank,
	// State
	output reg  [BANKS-1:0] open_map
);
	wire [BANKS-1:0] sel = {{(BANKS-1){1'b0}}, 1'b1} << bank;

	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			open_map <= {BANKS{1'b0}};
		end else if (clr) begin
			open_map <= {BANKS{1'b0}};
		end else if (close_en && close_all) begin
			open_map <= {BANKS{1'b0}};
		end else if (close_en) begin
			open_map <= open_map & ~sel;
		end else if (open_en) begin
			open_map <= open_map | sel;
		end
	end
endmodule
`default_nettype wire

// ==== logic/lpcd_decode.v ====
// Function
// - Non-idle commands span two link clock rises; idle spans one.
// - Chip select low at a first edge is idle; address pins ignored.
// - Bank close and row renew decode; all-banks flag on CA5, bank at second edge.
// - All-banks flag applies operation to every bank, bank bits ignored.
// - Self-renew entry and exit decode by their first-edge patterns.
// - Store, masked store, read first halves carry bank, column 9, auto-close.
// - Auto-close flag closes the addressed bank after the access, unless the column second half is non-target.
// - With on-the-fly sizing, burst select high means 32 beats, else 16.
// - Masked store uses 16 beats only; CA5 low at its first edge.
// - Column second half carries column 8..2; bits 1:0 zero; stores need 3:2 low.
// - Multi-purpose command carries a seven-bit payload over two edges.
// - Setting store first then second carry index and eight payload bits.
// - Setting fetch first carries the index, then column second half.
// - Row open first then second assemble bank and a seventeen-bit row.
// - Optional non-target second half replaces column second half.
// - Reset selects set point 0, latency set 0 and code-zero latencies.
// - Reset disables bus inversion and termination.
// - Outputs stay high impedance while the reset pin is low.
`timescale 1ns/1ps
`default_nettype none
`include "lpcd_regs.vh"
module lpcd_decode #(
	parameter NT_SUPPORT = 1,
	parameter DRIVE_EDGES = 8
) (
	// System
	input  wire        SYS_CLK,
	input  wire        RSTN,
	// Link pins
	input  wire        LINK_CK,
	input  wire        LINK_CKE,
	input  wire        LINK_CS,
	input  wire [5:0]  LINK_CA,
	input  wire        RESET_PIN_N,
	// Configuration
	input  wire        BURST_OTF_EN,
	// Decoded command
	output reg         CMD_STROBE,
	output reg  [4:0]  CMD_KIND,
	output reg  [2:0]  CMD_BANK,
	output reg         CMD_ALL_BANKS,
	output reg  [16:0] CMD_ROW,
	output reg  [9:0]  CMD_COLUMN,
	output reg         CMD_AUTO_CLOSE,
	output reg         CMD_BURST32,
	output reg         CMD_NON_TARGET,
	output reg  [7:0]  CMD_PAYLOAD,
	output reg  [5:0]  CMD_INDEX,
	output reg         SEQ_ERROR,
	// Settings
	output reg  [1:0]  FSP_SEL,
	output reg         STORE_LAT_GROUP,
	output reg  [2:0]  STORE_LAT_CODE,
	output reg  [2:0]  FETCH_LAT_CODE,
	output reg  [2:0]  RECOVERY_CODE,
	output reg  [1:0]  BUS_INV_EN,
	output reg  [2:0]  CA_TERM,
	output reg  [2:0]  DQ_TERM,
	// State
	output wire [7:0]  BANK_OPEN,
	output reg         OUT_OE_N
);
	// ==========================================
	// Input synchronisation and edge finding
	wire [9:0] s;
	reg        ck_d;

	lpcd_sync #(.WIDTH(10)) u_sync (
		.clk  (SYS_CLK),
		.rstn (RSTN),
		.d    ({RESET_PIN_N, LINK_CKE, LINK_CS, LINK_CA, LINK_CK}),
		.q    (s)
	);

	wire       ck     = s[0];
	wire [5:0] ca     = s[6:1];
	wire       cs     = s[7];
	wire       cke    = s[8];
	wire       pin_rst = ~s[9];
	wire       edge_ok = ck & ~ck_d & cke & ~pin_rst;

	// ==========================================
	// First-edge decode
	function [4:0] fdec;
		input [5:0] c;
		begin
			if (c[0])
				fdec = c[1] ? `LPCD_K_ROW2 : `LPCD_K_ROW1;
			else begin
				case (c[4:0])
				`LPCD_P_MPC:    fdec = `LPCD_K_MPC;
				`LPCD_P_CLOSE:  fdec = `LPCD_K_CLOSE;
				`LPCD_P_RENEW:  fdec = `LPCD_K_RENEW;
				`LPCD_P_SRE:    fdec = `LPCD_K_SRE;
				`LPCD_P_SRX:    fdec = `LPCD_K_SRX;
				`LPCD_P_STORE:  fdec = `LPCD_K_STORE;
				`LPCD_P_MSTORE: fdec = c[5] ? `LPCD_K_RSVD : `LPCD_K_MSTORE;
				`LPCD_P_READ:   fdec = `LPCD_K_READ;
				`LPCD_P_COL:    fdec = `LPCD_K_COL;
				`LPCD_P_SSET1:  fdec = `LPCD_K_SSET1;
				`LPCD_P_SSET2:  fdec = `LPCD_K_SSET2;
				`LPCD_P_FETCH:  fdec = `LPCD_K_FETCH;
				default:        fdec = `LPCD_K_RSVD;
				endcase
			end
		end
	endfunction

	wire [4:0] fk = fdec(ca);

	// ==========================================
	// Sequencer state
	reg [2:0]  state;
	reg [4:0]  kind;
	reg [4:0]  pend;
	reg        f5;
	reg [5:0]  f_ca;
	reg [2:0]  p_bank;
	reg        p_c9;
	reg        p_ap;
	reg        p_bl;
	reg [7:0]  p_op;
	reg [5:0]  p_idx;
	reg [1:0]  quiet;
	reg [3:0]  drive;
	reg        open_en;
	reg        close_en;
	reg        close_all;

	// A waiting state that sees anything other than its partner abandons
	// the pending half and decodes the edge as a fresh first half
	wire col_hit  = cs & (fk == `LPCD_K_COL);
	wire nt_hit   = (NT_SUPPORT != 0) & ~cs & ~ca[0] & (ca[4:0] == `LPCD_P_COL);
	wire sset_hit = cs & (fk == `LPCD_K_SSET2);
	wire row_hit  = cs & (fk == `LPCD_K_ROW2);
	wire wait_miss =
		(state == `LPCD_S_COLW  && !(col_hit || nt_hit)) ||
		(state == `LPCD_S_SSETW && !sset_hit) ||
		(state == `LPCD_S_ROWW  && !row_hit) ||
		(state == `LPCD_S_QUIET && cs);
	wire take_first = (state == `LPCD_S_FIRST) || wait_miss;

	wire is_access = (pend == `LPCD_K_STORE) || (pend == `LPCD_K_MSTORE) ||
		(pend == `LPCD_K_READ);
	wire is_store  = (pend == `LPCD_K_STORE) || (pend == `LPCD_K_MSTORE);

	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ck_d           <= 1'b0;
			state          <= `LPCD_S_FIRST;
			kind           <= `LPCD_K_NONE;
			pend           <= `LPCD_K_NONE;
			f5             <= 1'b0;
			f_ca           <= 6'h00;
			p_bank         <= 3'h0;
			p_c9           <= 1'b0;
			p_ap           <= 1'b0;
			p_bl           <= 1'b0;
			p_op           <= 8'h00;
			p_idx          <= 6'h00;
			quiet          <= 2'h0;
			CMD_STROBE     <= 1'b0;
			CMD_KIND       <= `LPCD_K_NONE;
			CMD_BANK       <= 3'h0;
			CMD_ALL_BANKS  <= 1'b0;
			CMD_ROW        <= 17'h00000;
			CMD_COLUMN     <= 10'h000;
			CMD_AUTO_CLOSE <= 1'b0;
			CMD_BURST32    <= 1'b0;
			CMD_NON_TARGET <= 1'b0;
			CMD_PAYLOAD    <= 8'h00;
			CMD_INDEX      <= 6'h00;
			SEQ_ERROR      <= 1'b0;
			open_en        <= 1'b0;
			close_en       <= 1'b0;
			close_all      <= 1'b0;
		end else begin
			ck_d       <= ck;
			CMD_STROBE <= 1'b0;
			SEQ_ERROR  <= 1'b0;
			open_en    <= 1'b0;
			close_en   <= 1'b0;
			close_all  <= 1'b0;
			if (pin_rst) begin
				state <= `LPCD_S_FIRST;
			end else if (edge_ok) begin
				if (take_first) begin
					SEQ_ERROR <= wait_miss;
					if (cs) begin
						kind  <= fk;
						f5    <= ca[5];
						f_ca  <= ca;
						state <= `LPCD_S_SECOND;
						// Second halves without their first are consumed as no-ops
						if (fk == `LPCD_K_COL || fk == `LPCD_K_SSET2 || fk == `LPCD_K_ROW2) begin
							kind      <= `LPCD_K_RSVD;
							SEQ_ERROR <= 1'b1;
						end
					end else begin
						state <= `LPCD_S_FIRST;
					end
				end else if (state == `LPCD_S_QUIET) begin
					quiet <= quiet - 2'h1;
					if (quiet == 2'h1)
						state <= `LPCD_S_FIRST;
				end else if (state != `LPCD_S_SECOND) begin
					kind  <= nt_hit ? `LPCD_K_NTCOL : fk;
					f5    <= ca[5];
					f_ca  <= ca;
					state <= `LPCD_S_SECOND;
				end else begin
					state <= `LPCD_S_FIRST;
					CMD_KIND       <= kind;
					CMD_NON_TARGET <= 1'b0;
					case (kind)
					`LPCD_K_CLOSE, `LPCD_K_RENEW: begin
						CMD_STROBE    <= 1'b1;
						CMD_BANK      <= ca[2:0];
						CMD_ALL_BANKS <= f5;
						close_en      <= (kind == `LPCD_K_CLOSE);
						close_all     <= f5;
					end
					`LPCD_K_SRE, `LPCD_K_SRX: begin
						CMD_STROBE <= 1'b1;
					end
					`LPCD_K_MPC: begin
						p_op <= {1'b0, f5, ca};
						pend <= kind;
						if (f5 == 1'b1) begin
							state <= `LPCD_S_COLW;
						end else begin
							CMD_STROBE  <= 1'b1;
							CMD_PAYLOAD <= {1'b0, f5, ca};
							quiet       <= `LPCD_QUIET_N;
							state       <= `LPCD_S_QUIET;
						end
					end
					`LPCD_K_STORE, `LPCD_K_MSTORE, `LPCD_K_READ: begin
						pend   <= kind;
						p_bank <= ca[2:0];
						p_c9   <= ca[4];
						p_ap   <= ca[5];
						p_bl   <= (kind != `LPCD_K_MSTORE) & BURST_OTF_EN & f5;
						state  <= `LPCD_S_COLW;
					end
					`LPCD_K_FETCH: begin
						pend  <= kind;
						p_idx <= ca;
						p_ap  <= 1'b0;
						state <= `LPCD_S_COLW;
					end
					`LPCD_K_SSET1: begin
						p_idx    <= ca;
						p_op[7]  <= f5;
						state    <= `LPCD_S_SSETW;
					end
					`LPCD_K_SSET2: begin
						CMD_STROBE  <= 1'b1;
						CMD_PAYLOAD <= {p_op[7], f5, ca};
						CMD_INDEX   <= p_idx;
					end
					`LPCD_K_ROW1: begin
						p_bank <= ca[2:0];
						CMD_ROW[15:12] <= f_ca[5:2];
						CMD_ROW[16]    <= ca[3];
						CMD_ROW[11:10] <= ca[5:4];
						state  <= `LPCD_S_ROWW;
					end
					`LPCD_K_ROW2: begin
						CMD_STROBE   <= 1'b1;
						CMD_BANK     <= p_bank;
						CMD_ROW[9:6] <= f_ca[5:2];
						CMD_ROW[5:0] <= ca;
						open_en      <= 1'b1;
					end
					`LPCD_K_COL, `LPCD_K_NTCOL: begin
						CMD_STROBE     <= 1'b1;
						CMD_KIND       <= pend;
						CMD_NON_TARGET <= (kind == `LPCD_K_NTCOL);
						CMD_BANK       <= p_bank;
						CMD_COLUMN     <= {p_c9, f5, ca, 2'h0};
						CMD_AUTO_CLOSE <= is_access & p_ap;
						CMD_BURST32    <= p_bl;
						CMD_INDEX      <= p_idx;
						CMD_PAYLOAD    <= p_op;
						CMD_ALL_BANKS  <= 1'b0;
						SEQ_ERROR      <= (kind == `LPCD_K_COL) && is_store && (ca[1:0] != 2'h0);
						// Non-target halves address another die, so no bank moves here
						close_en       <= (kind == `LPCD_K_COL) & is_access & p_ap;
					end
					default: begin
						CMD_KIND <= `LPCD_K_NONE;
					end
					endcase
				end
			end
		end
	end

	// ==========================================
	// Settings: defaults at either reset, updated by setting store
	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			FSP_SEL         <= `LPCD_D_FSP;
			STORE_LAT_GROUP <= `LPCD_D_WLS;
			STORE_LAT_CODE  <= `LPCD_D_CODE;
			FETCH_LAT_CODE  <= `LPCD_D_CODE;
			RECOVERY_CODE   <= `LPCD_D_CODE;
			BUS_INV_EN      <= `LPCD_D_DBI;
			CA_TERM         <= `LPCD_D_ODT;
			DQ_TERM         <= `LPCD_D_ODT;
		end else if (pin_rst) begin
			FSP_SEL         <= `LPCD_D_FSP;
			STORE_LAT_GROUP <= `LPCD_D_WLS;
			STORE_LAT_CODE  <= `LPCD_D_CODE;
			FETCH_LAT_CODE  <= `LPCD_D_CODE;
			RECOVERY_CODE   <= `LPCD_D_CODE;
			BUS_INV_EN      <= `LPCD_D_DBI;
			CA_TERM         <= `LPCD_D_ODT;
			DQ_TERM         <= `LPCD_D_ODT;
		end else if (CMD_STROBE && CMD_KIND == `LPCD_K_SSET2) begin
			case (CMD_INDEX)
			`LPCD_IDX_MR1:  RECOVERY_CODE <= CMD_PAYLOAD[`LPCD_F_NWR];
			`LPCD_IDX_MR2: begin
				STORE_LAT_GROUP <= CMD_PAYLOAD[`LPCD_F_WLS];
				STORE_LAT_CODE  <= CMD_PAYLOAD[`LPCD_F_WL];
				FETCH_LAT_CODE  <= CMD_PAYLOAD[`LPCD_F_RL];
			end
			`LPCD_IDX_MR3:  BUS_INV_EN <= CMD_PAYLOAD[`LPCD_F_DBI];
			`LPCD_IDX_MR11: begin
				CA_TERM <= CMD_PAYLOAD[`LPCD_F_CAODT];
				DQ_TERM <= CMD_PAYLOAD[`LPCD_F_DQODT];
			end
			`LPCD_IDX_MR13: FSP_SEL <= CMD_PAYLOAD[`LPCD_F_FSP];
			default: ;
			endcase
		end
	end

	// ==========================================
	// Output drive window after a read or fetch; pins float in reset
	always @(posedge SYS_CLK or negedge RSTN) begin
		if (!RSTN) begin
			drive    <= 4'h0;
			OUT_OE_N <= 1'b1;
		end else if (pin_rst) begin
			drive    <= 4'h0;
			OUT_OE_N <= 1'b1;
		end else begin
			if (CMD_STROBE && !CMD_NON_TARGET &&
				(CMD_KIND == `LPCD_K_READ || CMD_KIND == `LPCD_K_FETCH))
				drive <= DRIVE_EDGES[3:0];
			else if (edge_ok && drive != 4'h0)
				drive <= drive - 4'h1;
			OUT_OE_N <= (drive == 4'h0);
		end
	end

	lpcd_banks #(.BANKS(8)) u_banks (
		.clk       (SYS_CLK),
		.rstn      (RSTN),
		.clr       (pin_rst),
		.open_en   (open_en),
		.close_en  (close_en),
		.close_all (close_all),
		.bank      (CMD_BANK),
		.open_map  (BANK_OPEN)
	);
endmodule
`default_nettype wire

// ==== logic/lpcd_decode_unused.v ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== tb/lpcd_decode_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpcd_regs.vh"
module lpcd_decode_asserts (
	// Clock and resets
	input wire logic       SYS_CLK,
	input wire logic       RSTN,
	input wire logic       RESET_PIN_N,
	// Decoded command
	input wire logic       CMD_STROBE,
	input wire logic [4:0] CMD_KIND,
	input wire logic [2:0] CMD_BANK,
	input wire logic       CMD_ALL_BANKS,
	input wire logic       CMD_AUTO_CLOSE,
	input wire logic       CMD_BURST32,
	// Settings and state
	input wire logic [1:0] FSP_SEL,
	input wire logic       STORE_LAT_GROUP,
	input wire logic [2:0] STORE_LAT_CODE,
	input wire logic [2:0] FETCH_LAT_CODE,
	input wire logic [2:0] RECOVERY_CODE,
	input wire logic [1:0] BUS_INV_EN,
	input wire logic [2:0] CA_TERM,
	input wire logic [2:0] DQ_TERM,
	input wire logic [7:0] BANK_OPEN,
	input wire logic       OUT_OE_N
);
	// ========
	// Properties
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RSTN);
	// Two link rises per command, so no strobe in the 8 cycles after a strobe
	property p_strobe_gap;
		CMD_STROBE |=> !CMD_STROBE [*8];
	endproperty
	a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too soon");
	// Five cycles leave room for the pin synchroniser
	property p_oe_reset;
		!RESET_PIN_N [*5] |-> OUT_OE_N;
	endproperty
	a_oe_reset: assert property (p_oe_reset) else $error("outputs driven in reset");
	property p_lat_dflt;
		!RESET_PIN_N [*5] |-> {FSP_SEL, STORE_LAT_GROUP, STORE_LAT_CODE, FETCH_LAT_CODE, RECOVERY_CODE} == 12'h000;
	endproperty
	a_lat_dflt: assert property (p_lat_dflt) else $error("latency defaults wrong");
	property p_inv_dflt;
		!RESET_PIN_N [*5] |-> {BUS_INV_EN, CA_TERM, DQ_TERM} == 8'h00;
	endproperty
	a_inv_dflt: assert property (p_inv_dflt) else $error("inversion or termination on");
	property p_close_all;
		CMD_STROBE && CMD_KIND == `LPCD_K_CLOSE && CMD_ALL_BANKS |-> ##2 BANK_OPEN == 8'h00;
	endproperty
	a_close_all: assert property (p_close_all) else $error("all-bank close left a bank open");
	property p_auto_close;
		CMD_STROBE && CMD_AUTO_CLOSE && (CMD_KIND inside {`LPCD_K_READ, `LPCD_K_STORE, `LPCD_K_MSTORE})
			|-> ##2 !BANK_OPEN[$past(CMD_BANK, 2)];
	endproperty
	a_auto_close: assert property (p_auto_close) else $error("auto close missed");
	property p_row_open;
		CMD_STROBE && CMD_KIND == `LPCD_K_ROW2 |-> ##2 BANK_OPEN[$past(CMD_BANK, 2)];
	endproperty
	a_row_open: assert property (p_row_open) else $error("row open left bank closed");
	property p_mstore_16;
		CMD_STROBE && CMD_KIND == `LPCD_K_MSTORE |-> !CMD_BURST32;
	endproperty
	a_mstore_16: assert property (p_mstore_16) else $error("masked store with long burst");
endmodule
bind lpcd_decode lpcd_decode_asserts i_chk (
	.SYS_CLK(SYS_CLK), .RSTN(RSTN), .RESET_PIN_N(RESET_PIN_N), .CMD_STROBE(CMD_STROBE),
	.CMD_KIND(CMD_KIND), .CMD_BANK(CMD_BANK), .CMD_ALL_BANKS(CMD_ALL_BANKS), .CMD_AUTO_CLOSE(CMD_AUTO_CLOSE),
	.CMD_BURST32(CMD_BURST32), .FSP_SEL(FSP_SEL), .STORE_LAT_GROUP(STORE_LAT_GROUP),
	.STORE_LAT_CODE(STORE_LAT_CODE), .FETCH_LAT_CODE(FETCH_LAT_CODE), .RECOVERY_CODE(RECOVERY_CODE),
	.BUS_INV_EN(BUS_INV_EN), .CA_TERM(CA_TERM), .DQ_TERM(DQ_TERM), .BANK_OPEN(BANK_OPEN), .OUT_OE_N(OUT_OE_N));
`default_nettype wire

// ==== tb/lpcd_ctrl_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpcd_ctrl_model #(
	parameter T_POST  = 2000000,
	parameter T_FIRST = 2000
) (
	// Link pins
	output logic       ck,
	output logic       cke,
	output logic       cs,
	output logic [5:0] ca,
	output logic       rst_n
);
	// ========
	// Start up
	initial begin
		ck = 1'b0;
		cke = 1'b0;
		cs = 1'b0;
		ca = 6'h00;
		rst_n = 1'b0;
	end
	// ========
	// One link rise, pins settled half a period on each side
	task automatic rise(input logic c, input logic [5:0] a);
		begin
			cs = c;
			ca = a;
			#160 ck = 1'b1;
			#160 ck = 1'b0;
		end
	endtask
	// Released pins show the inverse so a stale level never passes for data
	task automatic park();
		begin
			cs = 1'b0;
			ca = ~ca;
		end
	endtask
	// Single channel here, so every channel starts together
	task automatic init(input int hold_ns);
		int i;
		begin
			cke = 1'b0;
			rst_n = 1'b0;
			#(hold_ns) rst_n = 1'b1;
			#(T_POST);
			for (i = 0; i < 5; i++)
				rise(1'b0, ~ca);
			cke = 1'b1;
			#(T_FIRST);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/lpcd_decode_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "lpcd_regs.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module lpcd_decode_tb;
	// ========
	// Nets
	logic        sys_clk, rstn, burst_otf;
	wire         ck, cke, cs, rst_n, strobe, all_b, ap_o, b32, nt, seq_err, store_latency_group, oe_n;
	wire  [5:0]  ca, index;
	wire  [4:0]  kind;
	wire  [2:0]  bank, wl, rl, rec, cat, dqt;
	wire  [16:0] row;
	wire  [9:0]  column;
	wire  [7:0]  payload, bank_open;
	wire  [1:0]  fsp, inv;
	int          n_fail, cmp_count, n_stb, n_err, i, j, k, s0, e0;
	logic [19:0] sv;
	logic [16:0] rv;
	logic [9:0]  cv;
	logic [7:0]  v;
	logic [2:0]  b;
	logic        ap, bl;
	logic [4:0]  acc_p [3] = '{5'h02, 5'h04, 5'h0c};
	logic [4:0]  acc_k [3] = '{`LPCD_K_READ, `LPCD_K_STORE, `LPCD_K_MSTORE};
	logic [4:0]  two_p [4] = '{5'h10, 5'h08, 5'h18, 5'h14};
	logic [4:0]  two_k [4] = '{`LPCD_K_CLOSE, `LPCD_K_RENEW, `LPCD_K_SRE, `LPCD_K_SRX};
	logic [5:0]  idx [5] = '{6'h01, 6'h02, 6'h03, 6'h0b, 6'h0d};
	lpcd_ctrl_model #(.T_POST(20000), .T_FIRST(2000)) i_mdl (.ck(ck), .cke(cke), .cs(cs), .ca(ca), .rst_n(rst_n));
	lpcd_decode i_dut (
		.SYS_CLK(sys_clk), .RSTN(rstn), .LINK_CK(ck), .LINK_CKE(cke), .LINK_CS(cs), .LINK_CA(ca),
		.RESET_PIN_N(rst_n), .BURST_OTF_EN(burst_otf), .CMD_STROBE(strobe), .CMD_KIND(kind), .CMD_BANK(bank),
		.CMD_ALL_BANKS(all_b), .CMD_ROW(row), .CMD_COLUMN(column), .CMD_AUTO_CLOSE(ap_o), .CMD_BURST32(b32),
		.CMD_NON_TARGET(nt), .CMD_PAYLOAD(payload), .CMD_INDEX(index), .SEQ_ERROR(seq_err), .FSP_SEL(fsp),
		.STORE_LAT_GROUP(store_latency_group), .STORE_LAT_CODE(wl), .FETCH_LAT_CODE(rl), .RECOVERY_CODE(rec), .BUS_INV_EN(inv),
		.CA_TERM(cat), .DQ_TERM(dqt), .BANK_OPEN(bank_open), .OUT_OE_N(oe_n));
	// ========
	// Clock and event counts
	always #20 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (strobe === 1'b1)
			n_stb++;
		if (seq_err === 1'b1)
			n_err++;
	end
	// ========
	// Helpers
	function automatic logic [19:0] nxt(input logic [19:0] s, input logic [5:0] ix, input logic [7:0] p);
		nxt = s;
		case (ix)
			6'h01: nxt[10:8] = p[6:4];
			6'h02: nxt[17:11] = p[6:0];
			6'h03: nxt[7:6] = p[7:6];
			6'h0b: nxt[5:0] = {p[6:4], p[2:0]};
			default: nxt[19:18] = p[7:6];
		endcase
	endfunction
	task automatic cmd(input logic [4:0] p, input logic b5, input logic [5:0] a2);
		begin
			i_mdl.rise(1'b1, {b5, p});
			i_mdl.rise(1'b0, a2);
		end
	endtask
	task automatic row_open(input logic [2:0] bb, input logic [16:0] r);
		begin
			cmd({r[14:12], 2'b01}, r[15], {r[11], r[10], r[16], bb});
			cmd({r[8:6], 2'b11}, r[9], r[5:0]);
		end
	endtask
	task automatic expect_n(input int ds, input int de);
		begin
			i_mdl.park();
			repeat (6) @(posedge sys_clk);
			#2;
			`CHK(n_stb - s0, ds);
			`CHK(n_err - e0, de);
			s0 = n_stb;
			e0 = n_err;
		end
	endtask
	task automatic dflt();
		begin
			sv = 20'h00000;
			`CHK({fsp, store_latency_group, wl, rl, rec}, 12'h000);
			`CHK({inv, cat, dqt}, 8'h00);
			`CHK(oe_n, 1'b1);
		end
	endtask
	task automatic tally_and_finish();
		begin
			$display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
			if (n_fail == 0 && cmp_count > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	// ========
	// Watchdog, far beyond the few hundred microseconds the tests need
	initial begin
		#1000000;
		$display("ERROR %0t: watchdog expired", $time);
		n_fail++;
		tally_and_finish();
	end
	// ========
	// Tests
	initial begin
		sys_clk = 1'b0;
		rstn = 1'b0;
		burst_otf = 1'b0;
		k = $urandom(32'hc791);
		repeat (10) @(posedge sys_clk);
		#2;
		rstn = 1'b1;
		i_mdl.init(200000);
		dflt();
		s0 = n_stb;
		e0 = n_err;
		for (i = 0; i < 12; i++) begin
			k = i % 3;
			b = 3'($urandom);
			rv = 17'($urandom);
			cv = (i < 3) ? 10'h3f0 : (i < 6) ? 10'h000 : 10'($urandom) & 10'h3fc;
			if (k != 0)
				cv[3:2] = 2'b00;
			ap = 1'($urandom);
			bl = 1'($urandom);
			burst_otf = 1'($urandom);
			row_open(b, rv);
			expect_n(1, 0);
			`CHK({kind, row, bank_open[b]}, {`LPCD_K_ROW2, rv, 1'b1});
			cmd(acc_p[k], (k == 2) ? 1'b0 : bl, {ap, cv[9], 1'b0, b});
			cmd(5'h12, cv[8], cv[7:2]);
			expect_n(1, 0);
			`CHK({kind, bank, column, ap_o}, {acc_k[k], b, cv, ap});
			`CHK(b32, bl & burst_otf & (k != 2));
			`CHK(bank_open[b], ~ap);
		end
		row_open(3'h5, 17'h1abcd);
		expect_n(1, 0);
		for (j = 0; j < 4; j++) begin
			b = 3'($urandom);
			cmd(two_p[j], j == 0, {3'b000, b});
			expect_n(1, 0);
			`CHK(kind, two_k[j]);
			if (j == 0)
				`CHK({all_b, bank_open}, 9'h100);
			if (j == 1)
				`CHK({all_b, bank}, {1'b0, b});
		end
		for (j = 0; j < 5; j++) begin
			v = 8'($urandom);
			cmd(5'h06, v[7], idx[j]);
			cmd(5'h16, v[6], v[5:0]);
			expect_n(1, 0);
			sv = nxt(sv, idx[j], v);
			`CHK({payload, index}, {v, idx[j]});
			`CHK({fsp, store_latency_group, wl, rl, rec, inv, cat, dqt}, sv);
		end
		cmd(5'h0e, 1'b0, 6'h2a);
		cmd(5'h12, 1'b0, 6'h00);
		expect_n(1, 0);
		`CHK({kind, index}, {`LPCD_K_FETCH, 6'h2a});
		`CHK(oe_n, 1'b0);
		v = 8'($urandom);
		cmd(5'h00, 1'b1, v[5:0]);
		cmd(5'h12, 1'b0, 6'h00);
		expect_n(1, 0);
		`CHK({kind, payload}, {`LPCD_K_MPC, 2'b01, v[5:0]});
		v = 8'($urandom);
		cmd(5'h00, 1'b0, v[5:0]);
		i_mdl.rise(1'b0, ~v[5:0]);
		i_mdl.rise(1'b0, v[5:0]);
		expect_n(1, 0);
		`CHK({kind, payload}, {`LPCD_K_MPC, 2'b00, v[5:0]});
		cmd(5'h12, 1'b1, 6'h3f);
		expect_n(0, 1);
		cmd(5'h02, 1'b0, 6'h05);
		i_mdl.rise(1'b0, 6'h00);
		expect_n(0, 1);
		cmd(5'h02, 1'b0, 6'h05);
		i_mdl.rise(1'b0, 6'h12);
		i_mdl.rise(1'b0, 6'h2b);
		expect_n(1, 0);
		`CHK(nt, 1'b1);
		for (j = 0; j < 3; j++)
			i_mdl.rise(1'b0, 6'($urandom));
		cmd(5'h1c, 1'b1, 6'h3f);
		expect_n(0, 0);
		`CHK(bank_open, 8'h00);
		i_mdl.init(400);
		dflt();
		tally_and_finish();
	end
endmodule
`default_nettype wire
